// file: sbtr_regs.vh
// register offsets, field positions and reset values of the two-channel 16-bit timer block
`ifndef SBTR_REGS_VH
`define SBTR_REGS_VH
`define SBTR_PRINT_T4_CMP_FIRST 20'h481A0
`define SBTR_PRINT_T4_CMP_SECOND 20'h481A2
`define SBTR_PRINT_T4_COUNT 20'h481A4
`define SBTR_PRINT_T4_CTRL 20'h481A6
`define SBTR_PRINT_T5_CMP_FIRST 20'h481A8
`define SBTR_PRINT_T5_CMP_SECOND 20'h481AA
`define SBTR_PRINT_T5_COUNT 20'h481AC
`define SBTR_PRINT_T5_CTRL 20'h481AE
`define SBTR_IDX_BASE 20'h481A0
`define SBTR_WIDX_CMP_FIRST 2'h0
`define SBTR_WIDX_CMP_SECOND 2'h1
`define SBTR_WIDX_COUNT 2'h2
`define SBTR_WIDX_CTRL 2'h3
`define SBTR_BIT_RUN 0
`define SBTR_BIT_CNT_RESET 1
`define SBTR_BIT_CLK_OUT_GATE 2
`define SBTR_BIT_CLK_SRC 3
`define SBTR_BIT_OUT_INV 4
`define SBTR_BIT_CMP_BUF 5
`define SBTR_BIT_FINE 6
`define SBTR_CTRL_RESET 8'h00
`define SBTR_CTRL_RW_MASK 8'h7D
`define SBTR_CMP_RESET 16'h0000
`define SBTR_COUNT_RESET 16'h0000
`endif

// file: sbtr_channel.v
// one 16-bit compare timer channel with control register and count logic
`default_nettype none
`include "sbtr_regs.vh"
module sbtr_channel #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire ref_clk,
  input wire srst,
  // register writes
  input wire wr_cmp_first,
  input wire wr_cmp_second,
  input wire wr_ctrl,
  input wire [WIDTH-1:0] wr_data,
  // count clocks
  input wire int_tick,
  input wire ext_tick,
  // register views
  output wire [WIDTH-1:0] cmp_first,
  output wire [WIDTH-1:0] cmp_second,
  output wire [WIDTH-1:0] count,
  output wire [7:0] ctrl,
  // pin
  output reg timer_out,
  output wire timer_out_en
);
  reg [WIDTH-1:0] cmp_first_reg;
  reg [WIDTH-1:0] cmp_second_reg;
  reg [WIDTH-1:0] act_first_reg;
  reg [WIDTH-1:0] act_second_reg;
  reg [WIDTH-1:0] count_reg;
  reg [7:0] ctrl_reg;
  reg toggle_reg;
  wire run_stop_bit = ctrl_reg[`SBTR_BIT_RUN];
  wire clock_output_gate = ctrl_reg[`SBTR_BIT_CLK_OUT_GATE];
  wire count_clock_source = ctrl_reg[`SBTR_BIT_CLK_SRC];
  wire output_polarity_invert = ctrl_reg[`SBTR_BIT_OUT_INV];
  wire compare_buffer_enable = ctrl_reg[`SBTR_BIT_CMP_BUF];
  wire fine_output_select = ctrl_reg[`SBTR_BIT_FINE];
  wire tick = count_clock_source ? ext_tick : int_tick; // [RULE_07]
  wire cnt_clear = wr_ctrl & wr_data[`SBTR_BIT_CNT_RESET]; // [RULE_05]
  wire hit_second = tick & run_stop_bit & (count_reg == act_second_reg);
  wire hit_first = tick & run_stop_bit & (count_reg == act_first_reg);
  assign cmp_first = cmp_first_reg; // [RULE_01]
  assign cmp_second = cmp_second_reg; // [RULE_02]
  assign count = count_reg; // [RULE_03]
  assign ctrl = ctrl_reg & `SBTR_CTRL_RW_MASK; // [RULE_05] [RULE_11]
  assign timer_out_en = clock_output_gate; // [RULE_06]
  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg <= `SBTR_CTRL_RESET; // [RULE_04] [RULE_11]
    end else if (wr_ctrl) begin
      ctrl_reg <= wr_data[7:0] & `SBTR_CTRL_RW_MASK;
    end
  end
  // cleared at reset for determinism though software must not rely on it
  always @(posedge ref_clk) begin
    if (srst) begin
      cmp_first_reg <= `SBTR_CMP_RESET;
      cmp_second_reg <= `SBTR_CMP_RESET;
      act_first_reg <= `SBTR_CMP_RESET;
      act_second_reg <= `SBTR_CMP_RESET;
    end else begin
      if (wr_cmp_first) begin
        cmp_first_reg <= wr_data; // [RULE_01]
      end
      if (wr_cmp_second) begin
        cmp_second_reg <= wr_data; // [RULE_02]
      end
      // buffered values load only at period end or on a counter clear, so a period is never torn
      if (!compare_buffer_enable || hit_second || cnt_clear) begin
        act_first_reg <= wr_cmp_first ? wr_data : cmp_first_reg; // [RULE_09]
        act_second_reg <= wr_cmp_second ? wr_data : cmp_second_reg; // [RULE_09]
      end
    end
  end
  always @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= `SBTR_COUNT_RESET;
      toggle_reg <= 1'b0;
    end else if (cnt_clear) begin
      count_reg <= `SBTR_COUNT_RESET; // [RULE_05]
      toggle_reg <= 1'b0;
    end else if (hit_second) begin
      count_reg <= `SBTR_COUNT_RESET; // [RULE_12]
      toggle_reg <= 1'b0; // [RULE_12]
    end else if (tick & run_stop_bit) begin
      count_reg <= count_reg + 1'b1; // [RULE_04] [RULE_12]
      if (hit_first) begin
        toggle_reg <= 1'b1; // [RULE_12]
      end
    end
  end
  // fine mode drives the half-clock refinement by holding a high level one extra cycle
  reg fine_hold_reg;
  always @(posedge ref_clk) begin
    if (srst) begin
      fine_hold_reg <= 1'b0;
      timer_out <= 1'b0;
    end else begin
      fine_hold_reg <= toggle_reg;
      timer_out <= (fine_output_select ? (toggle_reg | fine_hold_reg) : toggle_reg)
        ^ output_polarity_invert; // [RULE_10] [RULE_08]
    end
  end
endmodule // sbtr_channel
`default_nettype wire

// file: sbtr_top.v
// two-channel 16-bit timer register block behind an avalon-mm slave
//
// Behaviour
// [RULE_01] each channel has a 16-bit read/write first compare value
// [RULE_02] each channel has a separate 16-bit read/write second compare value
// [RULE_03] current count reads back as 16 bits; writes to it are ignored
// [RULE_04] control bit 0 runs the counter when 1, stops it when 0
// [RULE_05] writing 1 to control bit 1 clears the counter; reads 0
// [RULE_06] control bit 2 enables the timer output onto its pin
// [RULE_07] control bit 3 picks external clock input, else internal prescaled tick
// [RULE_08] control bit 4 inverts output polarity
// [RULE_09] control bit 5 buffers compare values until period end
// [RULE_10] control bit 6 selects fine output mode
// [RULE_11] control bit 7 reserved, reads 0
// [RULE_12] counter counts ticks, second compare wraps to zero, output toggles at matches
//
// Register access over Avalon-MM was chosen for this implementation.
`default_nettype none
`include "sbtr_regs.vh"
module sbtr_top #(
  parameter PRESCALE = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire srst,
  // avalon-mm slave, word address
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // external count clocks
  input wire t4_ext_clk,
  input wire t5_ext_clk,
  // timer outputs
  output wire t4_out,
  output wire t4_out_en,
  output wire t5_out,
  output wire t5_out_en
);
  // bus handshake states: a request waits one cycle, then is taken
  localparam [1:0] BUS_IDLE = 2'b00;
  localparam [1:0] BUS_DONE = 2'b01;
  // last prescaler count, compared at full integer width so no bits are lost
  localparam integer PRE_LAST = PRESCALE - 1;
  // bus handshake and read path
  reg [1:0] bus_state_reg;
  reg [1:0] bus_state_next;
  reg bus_wait;
  reg [31:0] rd_mux_next;
  // internal prescaler
  reg [15:0] pre_reg;
  reg [15:0] pre_next;
  // external clock synchronisers
  reg ext4_meta_reg;
  reg ext4_sync_reg;
  reg ext4_last_reg;
  reg ext5_meta_reg;
  reg ext5_sync_reg;
  reg ext5_last_reg;
  // channel register views
  wire [15:0] c4_first;
  wire [15:0] c4_second;
  wire [15:0] c4_count;
  wire [7:0] c4_ctrl;
  wire [15:0] c5_first;
  wire [15:0] c5_second;
  wire [15:0] c5_count;
  wire [7:0] c5_ctrl;
  // request decode
  wire bus_req = avs_read | avs_write;
  wire in_map = (avs_address[4:3] == 2'b00);
  wire sel_ch5 = avs_address[2];
  wire [1:0] widx = avs_address[1:0];
  wire sel_first = in_map & (widx == `SBTR_WIDX_CMP_FIRST);
  wire sel_second = in_map & (widx == `SBTR_WIDX_CMP_SECOND);
  wire sel_ctrl = in_map & (widx == `SBTR_WIDX_CTRL);
  wire rd_launch = avs_read & (bus_state_reg == BUS_IDLE);
  // writes land only at the edge where waitrequest is sampled low
  wire wr_accept = avs_write & (bus_state_reg == BUS_DONE);
  wire lo_en = avs_byteenable[0];
  // compares take whole halfwords only, so a half-written period never runs
  wire hw_en = avs_byteenable[0] & avs_byteenable[1];
  // count slots get no write strobe at all
  wire t4_wr_first = wr_accept & ~sel_ch5 & sel_first & hw_en; // [RULE_01]
  wire t4_wr_second = wr_accept & ~sel_ch5 & sel_second & hw_en; // [RULE_02]
  wire t4_wr_ctrl = wr_accept & ~sel_ch5 & sel_ctrl & lo_en; // [RULE_03]
  wire t5_wr_first = wr_accept & sel_ch5 & sel_first & hw_en; // [RULE_01]
  wire t5_wr_second = wr_accept & sel_ch5 & sel_second & hw_en; // [RULE_02]
  wire t5_wr_ctrl = wr_accept & sel_ch5 & sel_ctrl & lo_en; // [RULE_03]
  // count sources
  wire int_tick = ({16'h0000, pre_reg} == PRE_LAST); // [RULE_07]
  wire ext4_tick = ext4_sync_reg & ~ext4_last_reg; // [RULE_07]
  wire ext5_tick = ext5_sync_reg & ~ext5_last_reg; // [RULE_07]
  // bus handshake
  always @* begin
    bus_state_next = BUS_IDLE;
    bus_wait = 1'b0;
    case (bus_state_reg)
      BUS_IDLE: begin
        bus_wait = bus_req;
        bus_state_next = bus_req ? BUS_DONE : BUS_IDLE;
      end
      BUS_DONE: begin
        bus_wait = 1'b0;
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_wait = bus_req;
        bus_state_next = BUS_IDLE;
      end
    endcase
  end
  assign avs_waitrequest = bus_wait;
  always @(posedge ref_clk) begin
    if (srst) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end
  // read data is registered at launch and stands through the accepting edge
  always @* begin
    rd_mux_next = 32'h00000000;
    if (in_map) begin
      case ({sel_ch5, widx})
        {1'b0, `SBTR_WIDX_CMP_FIRST}: rd_mux_next = {16'h0000, c4_first}; // [RULE_01]
        {1'b0, `SBTR_WIDX_CMP_SECOND}: rd_mux_next = {16'h0000, c4_second}; // [RULE_02]
        {1'b0, `SBTR_WIDX_COUNT}: rd_mux_next = {16'h0000, c4_count}; // [RULE_03]
        {1'b0, `SBTR_WIDX_CTRL}: rd_mux_next = {24'h000000, c4_ctrl}; // [RULE_11]
        {1'b1, `SBTR_WIDX_CMP_FIRST}: rd_mux_next = {16'h0000, c5_first}; // [RULE_01]
        {1'b1, `SBTR_WIDX_CMP_SECOND}: rd_mux_next = {16'h0000, c5_second}; // [RULE_02]
        {1'b1, `SBTR_WIDX_COUNT}: rd_mux_next = {16'h0000, c5_count}; // [RULE_03]
        {1'b1, `SBTR_WIDX_CTRL}: rd_mux_next = {24'h000000, c5_ctrl}; // [RULE_11]
        default: rd_mux_next = 32'h00000000;
      endcase
    end
  end
  always @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_launch) begin
      avs_readdata <= rd_mux_next;
    end
  end
  // shared internal tick; a prescale above the counter range never ticks
  always @* begin
    pre_next = int_tick ? 16'h0000 : pre_reg + 16'h0001;
  end
  always @(posedge ref_clk) begin
    if (srst) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_next;
    end
  end
  // a pin held high through reset gives one false tick, harmless while stopped
  always @(posedge ref_clk) begin
    if (srst) begin
      ext4_meta_reg <= 1'b0;
      ext4_sync_reg <= 1'b0;
      ext4_last_reg <= 1'b0;
    end else begin
      ext4_meta_reg <= t4_ext_clk;
      ext4_sync_reg <= ext4_meta_reg;
      ext4_last_reg <= ext4_sync_reg;
    end
  end
  always @(posedge ref_clk) begin
    if (srst) begin
      ext5_meta_reg <= 1'b0;
      ext5_sync_reg <= 1'b0;
      ext5_last_reg <= 1'b0;
    end else begin
      ext5_meta_reg <= t5_ext_clk;
      ext5_sync_reg <= ext5_meta_reg;
      ext5_last_reg <= ext5_sync_reg;
    end
  end
  sbtr_channel #(.WIDTH(16)) u_ch4 (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr_cmp_first(t4_wr_first),
    .wr_cmp_second(t4_wr_second),
    .wr_ctrl(t4_wr_ctrl),
    .wr_data(avs_writedata[15:0]),
    .int_tick(int_tick),
    .ext_tick(ext4_tick),
    .cmp_first(c4_first),
    .cmp_second(c4_second),
    .count(c4_count),
    .ctrl(c4_ctrl),
    .timer_out(t4_out),
    .timer_out_en(t4_out_en)
  );
  sbtr_channel #(.WIDTH(16)) u_ch5 (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr_cmp_first(t5_wr_first),
    .wr_cmp_second(t5_wr_second),
    .wr_ctrl(t5_wr_ctrl),
    .wr_data(avs_writedata[15:0]),
    .int_tick(int_tick),
    .ext_tick(ext5_tick),
    .cmp_first(c5_first),
    .cmp_second(c5_second),
    .count(c5_count),
    .ctrl(c5_ctrl),
    .timer_out(t5_out),
    .timer_out_en(t5_out_en)
  );
endmodule // sbtr_top
`default_nettype wire

// file: sbtr_monitor.sv
// concurrent checks on the timer block bus and pin ports
`default_nettype none
module sbtr_monitor #(
  parameter PRESCALE = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic t4_out_en,
  input wire logic t5_out_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire rack = avs_read && !avs_waitrequest;
  wire wack = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire ctl_rd = rack && avs_address[4:3] == 2'h0 && avs_address[1:0] == 2'h3;
  a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held beyond one cycle");
  a_rd_upper: assert property (rack |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_rd_unmapped: assert property (rack && avs_address > 5'h07 |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (ctl_rd |-> !avs_readdata[7])
    else $error("reserved control bit reads one");
  a_clear_reads0: assert property (ctl_rd |-> !avs_readdata[1])
    else $error("counter clear bit reads one");
  a_gate_four: assert property (wack && avs_address == 5'h03 |-> ##2 t4_out_en == $past(avs_writedata[2], 2))
    else $error("channel 4 output enable wrong");
  a_gate_five: assert property (wack && avs_address == 5'h07 |-> ##2 t5_out_en == $past(avs_writedata[2], 2))
    else $error("channel 5 output enable wrong");
endmodule // sbtr_monitor
bind sbtr_top sbtr_monitor #(.PRESCALE(PRESCALE)) mon_u (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .t4_out_en(t4_out_en), .t5_out_en(t5_out_en));
`default_nettype wire

// file: tb.sv
// self-checking bench for the two-channel timer block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, srst = 1, avs_read = 0, avs_write = 0, t4_ext_clk = 0, t5_ext_clk = 0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, t4_out, t4_out_en, t5_out, t5_out_en;
  logic [31:0] exp_q[$];
  logic [15:0] v;
  integer seed = 32'h252ae966, error_cnt = 0, n_compared = 0, i;
  always #2 ref_clk = ~ref_clk;
  sbtr_top #(.PRESCALE(2)) dut_u (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .t4_ext_clk(t4_ext_clk), .t5_ext_clk(t5_ext_clk), .t4_out(t4_out),
    .t4_out_en(t4_out_en), .t5_out(t5_out), .t5_out_en(t5_out_en));
  // one idle cycle between requests, so a release never meets a new raise
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) begin
      error_cnt++;
      $display("Error %0t: bus request not answered", $time);
      give_verdict;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("Error %0t: read %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_pin(input logic got, input logic e);
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("Error %0t: pin %b expected %b", $time, got, e);
    end
  endtask
  always @(posedge ref_clk) if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++) rd(i, 32'h0);
    $display("test reset values done");
    for (i = 0; i < 8; i += 4) begin
      v = $random(seed);
      wr(i, v);
      rd(i, v);
      wr(i + 1, ~v);
      rd(i + 1, {16'h0000, ~v});
      rd(i, v);
      wr(i + 2, v);
      rd(i + 2, 32'h0);
      wr(i + 3, 32'hFF);
      rd(i + 3, 32'h7D);
      wr(i + 3, 32'h0);
      wr(i + 3, 32'h2);
      rd(i + 2, 32'h0);
    end
    wr(9, 32'hFFFF);
    rd(9, 32'h0);
    $display("test register access done");
    // external ticks: second compare 5 wraps, eight ticks leave 2
    wr(0, 32'h3);
    wr(1, 32'h5);
    wr(3, 32'hA);
    wr(7, 32'hA);
    wr(3, 32'h9);
    repeat (8) begin
      repeat (4) @(posedge ref_clk);
      t4_ext_clk <= 1'b1;
      t5_ext_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t4_ext_clk <= 1'b0;
      t5_ext_clk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    wr(3, 32'h8);
    rd(2, 32'h2);
    rd(6, 32'h0);
    chk_pin(t4_out, 1'b0);
    $display("test counting done");
    // channel 5 on the internal tick passes its first compare of 2 well within 40 cycles
    wr(4, 32'h2);
    wr(5, 32'hFFFF);
    wr(7, 32'h3);
    repeat (40) @(posedge ref_clk);
    chk_pin(t5_out, 1'b1);
    wr(7, 32'h10);
    repeat (3) @(posedge ref_clk);
    chk_pin(t5_out, 1'b0);
    $display("test output pins done");
    repeat (2) @(posedge ref_clk);
    give_verdict;
  end
endmodule // tb
`default_nettype wire
